// [include/pon_pkg.sv]
// constants and types shared by both ends of the power-off notice link
// assumes one 25 MHz clock shared by host controller and card
// Operation
// [RULE1] host enables notice by writing powered-up first
// [RULE2] host writes urgent/relaxed code before power removal
// [RULE3] host waits busy release before removing power
// [RULE4] sleep/wake allowed while byte is powered-up
// [RULE5] host writes pre-sleep and waits DAT0 release
// [RULE6] sleeping card woken before power-down code
// [RULE7] later commands restore powered-up code
// [RULE8] writing zero after other value flags error
// [RULE9] urgent code finishes within switch timeout
// [RULE10] relaxed code finishes within relaxed time field
// [RULE11] host may use pre-sleep before sleep
// [RULE12] pre-sleep busy bounded by busy limit field
// [RULE13] sleep only via deselect then sleep/wake
// [RULE14] leaving sleep restores powered-up code
// [RULE15] priority interrupt aborts pre-sleep, restores code
// [RULE16] supplies kept until pre-sleep and sleep
// [RULE17] DAT0 held low while preparing
package pon_pkg;
    // extended_config_space byte addresses
    localparam logic [7:0] NOTICE_ADDR = 8'h22;
    localparam logic [7:0] SLEEP_LIMIT_ADDR = 8'hd8;
    localparam logic [7:0] RELAXED_TIME_ADDR = 8'hf7;
    // notice byte codes
    localparam logic [7:0] CODE_ZERO = 8'h00;
    localparam logic [7:0] POWERED_UP = 8'h01;
    localparam logic [7:0] URGENT_OFF = 8'h02;
    localparam logic [7:0] RELAXED_OFF = 8'h03;
    localparam logic [7:0] PRE_SLEEP = 8'h04;
    // read-only time fields, in units of TIME_UNIT_US
    localparam logic [7:0] SLEEP_LIMIT_RST = 8'h14;
    localparam logic [7:0] RELAXED_TIME_RST = 8'h28;
    // timing
    localparam int CLK_MHZ = 25;
    localparam int TIME_UNIT_US = 100;
    localparam int TIME_UNIT_CYC = TIME_UNIT_US * CLK_MHZ;
    localparam int SWITCH_TMO_US = 1000;
    localparam int SWITCH_TMO_CYC = SWITCH_TMO_US * CLK_MHZ;
    localparam int PREP_WORK_CYC = 1000;
    localparam logic [1:0] BUSY_GUARD = 2'h3;
    // host register byte offsets and fields
    localparam logic [4:0] CMD_OFS = 5'h00;
    localparam logic [4:0] PRIO_OFS = 5'h04;
    localparam logic [4:0] STAT_OFS = 5'h08;
    localparam logic [4:0] IRQ_OFS = 5'h0c;
    localparam logic [4:0] MASK_OFS = 5'h10;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_DATA_LSB = 16;
    localparam int IRQ_W = 4;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_SWITCH = 3'h1,
        OP_READ = 3'h2,
        OP_SLEEP_WAKE = 3'h3,
        OP_SELECT = 3'h4,
        OP_DESELECT = 3'h5,
        OP_OTHER = 3'h6
    } pon_op_e;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_PREP = 2'b01,
        ST_SLEEP = 2'b10
    } pon_dev_e;

    function automatic logic pon_is_prep(input logic [7:0] code);
        return code == URGENT_OFF || code == RELAXED_OFF ||
               code == PRE_SLEEP;
    endfunction

    function automatic logic pon_is_off(input logic [7:0] code);
        return code == URGENT_OFF || code == RELAXED_OFF;
    endfunction
endpackage

// [include/pon_link_if.sv]
// command-level link between host controller and card
// dat0 models the pulled-up DAT0 wire; only the card drives it
`timescale 1ns/1ps
interface pon_link_if;
    logic cmd_valid;
    logic [2:0] cmd_op;
    logic [7:0] cmd_addr;
    logic [7:0] cmd_data;
    logic high_priority_interrupt;
    logic rsp_valid;
    logic rsp_err;
    logic [7:0] rsp_data;
    logic dat0_out;
    logic dat0_oe;
    logic dat0;

    // pull-up wins when nobody drives
    assign dat0 = dat0_oe ? dat0_out : 1'b1;

    modport dev (
        input cmd_valid, cmd_op, cmd_addr, cmd_data,
        input high_priority_interrupt,
        output rsp_valid, rsp_err, rsp_data, dat0_out, dat0_oe
    );
    modport host (
        output cmd_valid, cmd_op, cmd_addr, cmd_data,
        output high_priority_interrupt,
        input rsp_valid, rsp_err, rsp_data, dat0
    );
endinterface

// [src/pon_device.sv]
// card end: notice byte, preparation busy on DAT0, sleep state
// assumes the host keeps its own sequencing duties
`timescale 1ns/1ps
module pon_device
    import pon_pkg::*;
#(
    parameter int CNT_W = 24,
    parameter int SWITCH_LIMIT_CYC = SWITCH_TMO_CYC,
    parameter int UNIT_CYC = TIME_UNIT_CYC,
    parameter int WORK_CYC = PREP_WORK_CYC,
    parameter logic [7:0] SLEEP_LIMIT = SLEEP_LIMIT_RST,
    parameter logic [7:0] RELAXED_TIME = RELAXED_TIME_RST
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // link
    pon_link_if.dev link,
    // card status
    output logic [7:0] notice,
    output logic asleep,
    output logic preparing
);
    pon_dev_e state_ff, nxt_state;
    logic [7:0] notice_ff, nxt_notice;
    logic sel_ff, nxt_sel;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt, lim_ff, nxt_lim;
    logic rsp_v_ff, rsp_err_ff, nxt_err;
    logic [7:0] rsp_d_ff, nxt_rd;
    logic dat0_oe_ff, asleep_ff;

    // last busy cycle: the shorter of own work and the advertised limit
    function automatic logic [CNT_W-1:0] end_of(input logic [7:0] code);
        int lim;
        if (code == URGENT_OFF) begin
            lim = SWITCH_LIMIT_CYC; // [RULE9]
        end else if (code == RELAXED_OFF) begin
            lim = UNIT_CYC * int'(RELAXED_TIME); // [RULE10]
        end else begin
            lim = UNIT_CYC * int'(SLEEP_LIMIT); // [RULE12]
        end
        if (lim > WORK_CYC) begin
            lim = WORK_CYC;
        end
        if (lim < 1) begin
            lim = 1;
        end
        return CNT_W'(lim - 1);
    endfunction

    wire logic cmd = link.cmd_valid;
    wire logic [7:0] val = link.cmd_data;
    wire logic to_notice = link.cmd_addr == NOTICE_ADDR;
    // deselect and sleep after pre-sleep are the sleep path, not an abort
    wire logic keep_pre = notice_ff == PRE_SLEEP &&
        (link.cmd_op == OP_DESELECT || link.cmd_op == OP_SLEEP_WAKE);
    wire logic restore = cmd && pon_is_prep(notice_ff) && !keep_pre;
    wire logic [7:0] base = restore ? POWERED_UP : notice_ff; // [RULE7]
    wire logic bad_zero = val == CODE_ZERO && base != CODE_ZERO;
    wire logic [7:0] rd_val =
        link.cmd_addr == NOTICE_ADDR ? base :
        link.cmd_addr == SLEEP_LIMIT_ADDR ? SLEEP_LIMIT :
        link.cmd_addr == RELAXED_TIME_ADDR ? RELAXED_TIME : 8'h00;

    always_comb begin
        nxt_state = state_ff;
        nxt_notice = notice_ff;
        nxt_sel = sel_ff;
        nxt_cnt = cnt_ff;
        nxt_lim = lim_ff;
        nxt_err = 1'b0;
        nxt_rd = 8'h00;
        case (state_ff)
            ST_PREP: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cmd || link.high_priority_interrupt) begin
                    nxt_notice = POWERED_UP; // [RULE7] [RULE15]
                    nxt_state = ST_ACTIVE;
                end else if (cnt_ff == lim_ff) begin
                    nxt_state = ST_ACTIVE; // [RULE9] [RULE10] [RULE12]
                end
            end
            ST_SLEEP: begin
                if (cmd && link.cmd_op == OP_SLEEP_WAKE) begin
                    nxt_state = ST_ACTIVE;
                    if (notice_ff != CODE_ZERO) begin
                        nxt_notice = POWERED_UP; // [RULE14]
                    end
                end else if (cmd) begin
                    nxt_err = 1'b1;
                end
            end
            default: begin
                if (cmd) begin
                    nxt_notice = base;
                    case (link.cmd_op)
                        OP_SWITCH: begin
                            if (!to_notice || bad_zero || val > PRE_SLEEP) begin
                                nxt_err = 1'b1; // [RULE8]
                            end else begin
                                nxt_notice = val;
                                if (pon_is_prep(val)) begin
                                    nxt_state = ST_PREP;
                                    nxt_cnt = '0;
                                    nxt_lim = end_of(val);
                                end
                            end
                        end
                        OP_READ: nxt_rd = rd_val;
                        OP_SELECT: nxt_sel = 1'b1;
                        OP_DESELECT: nxt_sel = 1'b0;
                        OP_SLEEP_WAKE: begin
                            if (sel_ff) begin
                                nxt_err = 1'b1;
                            end else begin
                                nxt_state = ST_SLEEP; // [RULE4]
                            end
                        end
                        default: nxt_err = 1'b0;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_ACTIVE;
            notice_ff <= CODE_ZERO;
            sel_ff <= 1'b1;
            cnt_ff <= '0;
            lim_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            notice_ff <= nxt_notice;
            sel_ff <= nxt_sel;
            cnt_ff <= nxt_cnt;
            lim_ff <= nxt_lim;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rsp_v_ff <= 1'b0;
            rsp_err_ff <= 1'b0;
            rsp_d_ff <= 8'h00;
            dat0_oe_ff <= 1'b0;
            asleep_ff <= 1'b0;
        end else begin
            rsp_v_ff <= cmd;
            rsp_err_ff <= nxt_err;
            rsp_d_ff <= nxt_rd;
            dat0_oe_ff <= nxt_state == ST_PREP; // [RULE17]
            asleep_ff <= nxt_state == ST_SLEEP;
        end
    end

    // busy is DAT0 driven low; released by dropping the enable
    assign link.dat0_out = 1'b0;
    assign link.dat0_oe = dat0_oe_ff;
    assign link.rsp_valid = rsp_v_ff;
    assign link.rsp_err = rsp_err_ff;
    assign link.rsp_data = rsp_d_ff;
    assign notice = notice_ff;
    assign asleep = asleep_ff;
    assign preparing = dat0_oe_ff;
endmodule

// [src/pon_host.sv]
// host controller end: Avalon-MM slave, command launch, notice sequencing
// assumes one Avalon master; card answers every command next cycle
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module pon_host
    import pon_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    // link
    pon_link_if.host link,
    // supply hints
    output logic power_off_ok,
    output logic core_off_ok
);
    logic s1_ff, s2_ff, busy_d_ff;
    logic wreq_ff, wait_rsp_ff, cmd_v_ff, prio_ff;
    logic [31:0] rdata_ff;
    logic [2:0] op_ff;
    logic [7:0] addr_ff, data_ff, hnotice_ff;
    logic [8:0] last_ff;
    logic enabled_ff, asleep_ff, pok_ff, cok_ff, irq_ff;
    logic [1:0] guard_ff;
    logic [IRQ_W-1:0] sts_ff, mask_ff;

    // DAT0 comes from the pin: only s2 is looked at
    wire logic busy = !s2_ff;
    wire logic busy_q = busy || guard_ff != 2'h0;
    wire logic req = (avs_read || avs_write) && wreq_ff && !wait_rsp_ff;
    wire logic at_cmd = avs_address == CMD_OFS;
    wire logic at_prio = avs_address == PRIO_OFS;
    wire logic at_stat = avs_address == STAT_OFS;
    wire logic at_irq = avs_address == IRQ_OFS;
    wire logic at_mask = avs_address == MASK_OFS;
    wire logic [2:0] w_op = avs_writedata[CMD_OP_LSB +: 3];
    wire logic [7:0] w_addr = avs_writedata[CMD_ADDR_LSB +: 8];
    wire logic [7:0] w_data = avs_writedata[CMD_DATA_LSB +: 8];
    wire logic w_notice = w_op == OP_SWITCH && w_addr == NOTICE_ADDR;
    wire logic stay_pre = hnotice_ff == PRE_SLEEP || hnotice_ff == POWERED_UP;
    wire logic refuse = busy_q // [RULE3] [RULE5]
        || (w_notice && pon_is_prep(w_data) && !enabled_ff) // [RULE1]
        || (w_notice && asleep_ff) // [RULE6]
        || (w_op == OP_SLEEP_WAKE && !asleep_ff && enabled_ff
            && !stay_pre); // [RULE4] [RULE13]
    wire logic wr_cmd = req && avs_write && at_cmd;
    wire logic launch = wr_cmd && !refuse;
    wire logic rsp = wait_rsp_ff && link.rsp_valid;
    wire logic done = (req && !launch) || rsp;
    wire logic ok_rsp = rsp && !link.rsp_err;
    wire logic rd_irq = req && avs_read && at_irq;
    wire logic [IRQ_W-1:0] events = {wr_cmd && refuse, busy_d_ff && !busy,
                                     rsp && link.rsp_err, rsp};
    wire logic [31:0] stat_word = {26'h000_0000, wait_rsp_ff, enabled_ff,
                                   cok_ff, pok_ff, asleep_ff, busy};
    wire logic [31:0] rd_mux =
        !avs_read ? 32'h0000_0000 :
        at_cmd ? {23'h00_0000, last_ff} :
        at_stat ? stat_word :
        at_irq ? {28'h000_0000, sts_ff} :
        at_mask ? {28'h000_0000, mask_ff} : 32'h0000_0000;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
            busy_d_ff <= 1'b0;
        end else begin
            s1_ff <= link.dat0;
            s2_ff <= s1_ff;
            busy_d_ff <= busy;
        end
    end

    // bus answer and command launch
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wreq_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
            wait_rsp_ff <= 1'b0;
            cmd_v_ff <= 1'b0;
            op_ff <= OP_NONE;
            addr_ff <= 8'h00;
            data_ff <= 8'h00;
            prio_ff <= 1'b0;
            last_ff <= 9'h000;
        end else begin
            wreq_ff <= !done;
            if (req && !launch) begin
                rdata_ff <= rd_mux;
            end
            cmd_v_ff <= launch;
            if (launch) begin
                op_ff <= w_op;
                addr_ff <= w_addr;
                data_ff <= w_data;
                wait_rsp_ff <= 1'b1;
            end else if (rsp) begin
                wait_rsp_ff <= 1'b0;
                last_ff <= {link.rsp_err, link.rsp_data};
            end
            prio_ff <= req && avs_write && at_prio && avs_writedata[0];
        end
    end

    // mirror of what the card holds, used for sequencing
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hnotice_ff <= CODE_ZERO;
            enabled_ff <= 1'b0;
            asleep_ff <= 1'b0;
            guard_ff <= 2'h0;
        end else begin
            if (guard_ff != 2'h0) begin
                guard_ff <= guard_ff - 1'b1;
            end
            if (prio_ff && busy_q && pon_is_prep(hnotice_ff)) begin
                hnotice_ff <= POWERED_UP;
            end else if (ok_rsp && op_ff == OP_SWITCH
                         && addr_ff == NOTICE_ADDR) begin
                hnotice_ff <= data_ff;
                if (data_ff == POWERED_UP) begin
                    enabled_ff <= 1'b1; // [RULE1]
                end
                if (pon_is_prep(data_ff)) begin
                    // covers sync delay before busy shows
                    guard_ff <= BUSY_GUARD; // [RULE3] [RULE5] [RULE11]
                end
            end else if (ok_rsp && op_ff == OP_SLEEP_WAKE) begin
                asleep_ff <= !asleep_ff;
                if (asleep_ff && enabled_ff) begin
                    hnotice_ff <= POWERED_UP;
                end
            end else if (ok_rsp && pon_is_prep(hnotice_ff)
                         && !(hnotice_ff == PRE_SLEEP
                              && op_ff == OP_DESELECT)) begin
                hnotice_ff <= POWERED_UP;
            end
        end
    end

    // interrupt status: read clears, new event wins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sts_ff <= IRQ_RST;
            mask_ff <= IRQ_RST;
            irq_ff <= 1'b0;
            pok_ff <= 1'b0;
            cok_ff <= 1'b0;
        end else begin
            sts_ff <= (rd_irq ? IRQ_RST : sts_ff) | events;
            if (req && avs_write && at_mask) begin
                mask_ff <= avs_writedata[IRQ_W-1:0];
            end
            irq_ff <= |(sts_ff & mask_ff);
            pok_ff <= pon_is_off(hnotice_ff) && !busy_q
                      && !wait_rsp_ff; // [RULE2] [RULE3]
            cok_ff <= asleep_ff && hnotice_ff == PRE_SLEEP; // [RULE16]
        end
    end

    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wreq_ff;
    assign irq = irq_ff;
    assign power_off_ok = pok_ff;
    assign core_off_ok = cok_ff;
    assign link.cmd_valid = cmd_v_ff;
    assign link.cmd_op = op_ff;
    assign link.cmd_addr = addr_ff;
    assign link.cmd_data = data_ff;
    assign link.high_priority_interrupt = prio_ff;
endmodule

// [verif/pon_checker.sv]
// link assertions for the host controller and card pair
// assumes one shared clk_sys; sees only the link signals
`timescale 1ns/1ps
module pon_checker
    import pon_pkg::*;
#(
    parameter int WORK_CYC = PREP_WORK_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // link
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_op,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    input wire logic high_priority_interrupt,
    input wire logic rsp_valid,
    input wire logic rsp_err,
    input wire logic [7:0] rsp_data,
    input wire logic dat0_out,
    input wire logic dat0_oe,
    input wire logic dat0
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [15:0] busy_cnt_ff;
    logic nz_pend_ff;
    logic nz_seen_ff;
    wire sw_hit = cmd_valid && cmd_op == OP_SWITCH && cmd_addr == NOTICE_ADDR;
    wire prep_code = cmd_data >= URGENT_OFF && cmd_data <= PRE_SLEEP;
    wire nz_code = cmd_data != CODE_ZERO && cmd_data <= PRE_SLEEP;
    // byte known nonzero only once a nonzero write was accepted
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_ff <= 16'h0000;
            nz_pend_ff <= 1'b0;
            nz_seen_ff <= 1'b0;
        end else begin
            busy_cnt_ff <= dat0_oe ? busy_cnt_ff + 16'h0001 : 16'h0000;
            nz_pend_ff <= sw_hit && nz_code && !dat0_oe;
            nz_seen_ff <= nz_seen_ff || (nz_pend_ff && rsp_valid && !rsp_err);
        end
    end
    property p_rsp_next;
        cmd_valid |=> rsp_valid ##1 !rsp_valid;
    endproperty
    a_rsp_next: assert property (p_rsp_next)
        else $error("response not one cycle after command");
    property p_rsp_cause;
        rsp_valid |-> $past(cmd_valid);
    endproperty
    a_rsp_cause: assert property (p_rsp_cause)
        else $error("response without command");
    property p_busy_cause;
        $rose(dat0_oe) |-> $past(sw_hit && prep_code);
    endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("busy without notice code");
    // busy lasts the full work time unless cut short; limits >= WORK_CYC
    property p_dat0_level;
        dat0_oe && !high_priority_interrupt && !cmd_valid
            && busy_cnt_ff < WORK_CYC - 1 |=> !dat0;
    endproperty
    a_dat0_level: assert property (p_dat0_level)
        else $error("dat0 level wrong");
    property p_hpi_abort;
        high_priority_interrupt && dat0_oe |-> ##[1:2] !dat0_oe;
    endproperty
    a_hpi_abort: assert property (p_hpi_abort)
        else $error("busy kept after interrupt");
    property p_zero_err;
        sw_hit && cmd_data == CODE_ZERO && nz_seen_ff && !dat0_oe
            |=> rsp_valid && rsp_err;
    endproperty
    a_zero_err: assert property (p_zero_err)
        else $error("zero write not flagged");
    property p_busy_len;
        busy_cnt_ff <= WORK_CYC;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy too long");
    property p_quiet_rsp;
        rsp_valid && $past(cmd_op) != OP_READ |-> rsp_data == 8'h00;
    endproperty
    a_quiet_rsp: assert property (p_quiet_rsp)
        else $error("data on non-read response");
    c_busy_end: cover property ($fell(dat0_oe));
    c_hpi: cover property (high_priority_interrupt && dat0_oe);
    c_err: cover property (rsp_valid && rsp_err);
endmodule

// [verif/power_off_notice_control_tb.sv]
// bench: host controller and card joined over one link
// assumes shortened card timings, every uninterrupted preparation lasts WORK cycles
`timescale 1ns/1ps
module power_off_notice_control_tb
    import pon_pkg::*;
;
    localparam int WORK = 10;
    localparam int SW_LIM = 20;
    localparam int UNIT = 4;
    logic clk_sys;
    logic rst_n;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic power_off_ok;
    logic core_off_ok;
    logic [7:0] notice;
    logic asleep;
    logic preparing;
    logic [31:0] rd;
    logic [31:0] seed;
    logic [7:0] code;
    int error_cnt;
    int check_count;
    int prep_cnt;
    pon_link_if link();
    pon_device #(.SWITCH_LIMIT_CYC(SW_LIM), .UNIT_CYC(UNIT),
        .WORK_CYC(WORK))
    pon_device_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
        .notice(notice), .asleep(asleep), .preparing(preparing));
    pon_host pon_host_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq), .link(link), .power_off_ok(power_off_ok),
        .core_off_ok(core_off_ok));
    pon_checker #(.WORK_CYC(WORK)) pon_checker_i (.clk_sys(clk_sys),
        .rst_n(rst_n), .cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op),
        .cmd_addr(link.cmd_addr), .cmd_data(link.cmd_data),
        .high_priority_interrupt(link.high_priority_interrupt),
        .rsp_valid(link.rsp_valid), .rsp_err(link.rsp_err),
        .rsp_data(link.rsp_data), .dat0_out(link.dat0_out),
        .dat0_oe(link.dat0_oe), .dat0(link.dat0));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (preparing === 1'b1) begin
            prep_cnt = prep_cnt + 1;
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // busy cycles: own work time, cut at the advertised limit
    function automatic int exp_busy(input logic [7:0] c);
        int lim;
        lim = c == URGENT_OFF ? SW_LIM :
            c == RELAXED_OFF ? UNIT * int'(RELAXED_TIME_RST) :
            UNIT * int'(SLEEP_LIMIT_RST);
        return lim < WORK ? lim : WORK;
    endfunction
    // holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] wd);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            chk(1'b0, 1'b1);
            complete_run();
        end
    endtask
    task automatic cmd(input pon_op_e op, input logic [7:0] a,
                       input logic [7:0] d);
        bus(1'b1, CMD_OFS, {8'h00, d, a, 5'h00, op});
        bus(1'b0, CMD_OFS, 32'h0000_0000);
    endtask
    // 6 cycles cover the host's two syncs and its 3-cycle guard
    task automatic wait_idle();
        int n;
        n = 0;
        while (preparing !== 1'b0 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        if (preparing !== 1'b0) begin
            chk(1'b0, 1'b1);
            complete_run();
        end
        repeat (6) @(posedge clk_sys);
    endtask
    initial begin
        rst_n = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        seed = 32'h8a78_00fd;
        error_cnt = 0;
        check_count = 0;
        prep_cnt = 0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        bus(1'b0, STAT_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        bus(1'b1, 5'h14, 32'hffff_ffff);
        bus(1'b0, 5'h14, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(notice, CODE_ZERO);
        $display("test reset done");
        bus(1'b1, MASK_OFS, 32'h0000_0002);
        cmd(OP_SWITCH, NOTICE_ADDR, POWERED_UP);
        chk(rd[8], 1'b0);
        chk(notice, POWERED_UP);
        chk(irq, 1'b0);
        cmd(OP_SWITCH, NOTICE_ADDR, CODE_ZERO);
        chk(rd[8], 1'b1);
        chk(notice, POWERED_UP);
        repeat (3) @(posedge clk_sys);
        chk(irq, 1'b1);
        bus(1'b0, IRQ_OFS, 32'h0000_0000);
        chk(rd[1], 1'b1);
        repeat (3) @(posedge clk_sys);
        chk(irq, 1'b0);
        for (int i = 0; i < 4; i++) begin
            code = 8'(5 + ($random(seed) & 32'hff) % 251);
            cmd(OP_SWITCH, NOTICE_ADDR, code);
            chk(rd[8], 1'b1);
            chk(notice, POWERED_UP);
        end
        $display("test enable done");
        for (int i = 0; i < 2; i++) begin
            code = i == 0 ? URGENT_OFF : RELAXED_OFF;
            prep_cnt = 0;
            bus(1'b1, CMD_OFS, {8'h00, code, NOTICE_ADDR, 5'h00, OP_SWITCH});
            chk(link.dat0, 1'b0);
            chk(notice, code);
            bus(1'b1, CMD_OFS, {24'h00_0022, 5'h00, OP_READ});
            bus(1'b0, IRQ_OFS, 32'h0000_0000);
            chk(rd[3], 1'b1);
            wait_idle();
            chk(prep_cnt, exp_busy(code));
            chk(link.dat0, 1'b1);
            chk(power_off_ok, 1'b1);
            cmd(OP_READ, NOTICE_ADDR, 8'h00);
            chk(rd[7:0], POWERED_UP);
        end
        $display("test power off done");
        prep_cnt = 0;
        bus(1'b1, CMD_OFS, {8'h00, PRE_SLEEP, NOTICE_ADDR, 5'h00, OP_SWITCH});
        bus(1'b1, PRIO_OFS, 32'h0000_0001);
        repeat (3) @(posedge clk_sys);
        chk(preparing, 1'b0);
        chk(notice, POWERED_UP);
        chk(prep_cnt < WORK, 1'b1);
        wait_idle();
        $display("test interrupt done");
        prep_cnt = 0;
        cmd(OP_SWITCH, NOTICE_ADDR, PRE_SLEEP);
        wait_idle();
        chk(prep_cnt, exp_busy(PRE_SLEEP));
        cmd(OP_DESELECT, 8'h00, 8'h00);
        cmd(OP_SLEEP_WAKE, 8'h00, 8'h00);
        chk(asleep, 1'b1);
        chk(notice, PRE_SLEEP);
        repeat (4) @(posedge clk_sys);
        chk(core_off_ok, 1'b1);
        cmd(OP_SLEEP_WAKE, 8'h00, 8'h00);
        chk(asleep, 1'b0);
        chk(notice, POWERED_UP);
        cmd(OP_SELECT, 8'h00, 8'h00);
        chk(rd[8], 1'b0);
        cmd(OP_DESELECT, 8'h00, 8'h00);
        cmd(OP_SLEEP_WAKE, 8'h00, 8'h00);
        chk(asleep, 1'b1);
        cmd(OP_SLEEP_WAKE, 8'h00, 8'h00);
        chk(asleep, 1'b0);
        $display("test sleep done");
        // reset in mid-run must bring both ends back to power-up values
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(notice, CODE_ZERO);
        chk(irq, 1'b0);
        rst_n <= 1'b1;
        bus(1'b0, STAT_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("test second reset done");
        complete_run();
    end
endmodule
